/* File: vmb_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the metadata buffer.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef VMB_PARAMS_SVH
`define VMB_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define VMB_ADDR_W          8
`define VMB_ADDR_CTL0       8'h00
`define VMB_ADDR_CTL1       8'h04
`define VMB_ADDR_CONF       8'h08
`define VMB_ADDR_HDR        8'h0C
`define VMB_ADDR_DATA0      8'h10
`define VMB_ADDR_DATA1      8'h14

// ****************************************
// Field positions
// ****************************************
`define VMB_CTL_AUTO_BIT    14
`define VMB_CTL_READY_BIT   16
`define VMB_CTL_EMPTY_BIT   24
`define VMB_CTL_CLEAR_BIT   25
`define VMB_CONF_COUNT_W    10
`define VMB_CONF_BLOCK_BIT  22
`define VMB_CONF_REPLAY_BIT 23
`define VMB_CONF_DONE_BIT   31

// ****************************************
// Reset values and sizes
// ****************************************
`define VMB_HDR_RESET       32'h0000_0000
`define VMB_BUF_WORDS       256
`define VMB_PKT_DWORDS      8
`define VMB_DW_CNT_W        4

// ****************************************
// Timing counts in scan lines
// ****************************************
`define VMB_LINE_W          12
`define VMB_START_LINE      12'h008
`define VMB_VRR_START_LINE  12'h003

`endif

/* File: vmb_pkg.sv */
// Purpose: Types shared by the metadata buffer modules.
// Assumes: Nothing beyond the parameter header.
// Notes:   Constants live in vmb_params.svh.
package vmb_pkg;

    typedef enum logic {
        ST_IDLE,
        ST_SEND
    } vmb_state_t;

endpackage

/* File: vmb_buf_if.sv */
// Purpose: Connection between the packet engine and one metadata buffer.
// Assumes: One clock; all signals are sampled on sys_clk_i.
// Notes:   AW holds one more bit than the word index so a full buffer is distinguishable.
`timescale 1ns/100ps
`default_nettype none

interface vmb_buf_if #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned AW    = 9
);
    logic             wr_en;
    logic [WIDTH-1:0] wr_data;
    logic             auto_inc;
    logic             rd_en;
    logic             rewind;
    logic             clear;
    logic [WIDTH-1:0] rd_data;
    logic [AW-1:0]    wr_ptr;
    logic             has_data;
    logic             rd_last;

    modport store (
        input  wr_en, wr_data, auto_inc, rd_en, rewind, clear,
        output rd_data, wr_ptr, has_data, rd_last
    );
    modport ctl (
        output wr_en, wr_data, auto_inc, rd_en, rewind, clear,
        input  rd_data, wr_ptr, has_data, rd_last
    );
endinterface

`default_nettype wire

/* File: vmb_meta_fifo.sv */
// Purpose: One sequential metadata buffer with write and read pointers.
// Assumes: Reads and writes are strictly sequential; no random addressing.
// Notes:   Read data is combinational from the array; the caller registers it.
`timescale 1ns/100ps
`default_nettype none
`include "vmb_params.svh"

module vmb_meta_fifo
    import vmb_pkg::*;
#(
    parameter int unsigned DEPTH = `VMB_BUF_WORDS,
    parameter int unsigned WIDTH = 32,
    parameter int unsigned AW    = $clog2(`VMB_BUF_WORDS) + 1
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // Buffer port
    vmb_buf_if.store  port_if
);
    generate
        if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0) || (AW != $clog2(DEPTH) + 1)) begin : g_bad
            $error("vmb_meta_fifo: DEPTH must be a power of two and AW must match it");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic             full;

    assign full = (wr_ptr_q == AW'(DEPTH));

    // ****************************************
    // Write side
    // ****************************************
    // Without auto increment the same word is overwritten by every write.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || port_if.clear) begin
            wr_ptr_q <= '0;
        end else if (port_if.wr_en && !full && port_if.auto_inc) begin
            wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (port_if.wr_en && !full && !port_if.clear) begin
            mem_q[wr_ptr_q[AW-2:0]] <= port_if.wr_data;
        end
    end

    // ****************************************
    // Read side
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || port_if.clear || port_if.rewind) begin
            rd_ptr_q <= '0;
        end else if (port_if.rd_en && port_if.has_data) begin
            rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
        end
    end

    assign port_if.rd_data  = mem_q[rd_ptr_q[AW-2:0]];
    assign port_if.wr_ptr   = wr_ptr_q;
    assign port_if.has_data = (rd_ptr_q != wr_ptr_q);
    assign port_if.rd_last  = (AW'(rd_ptr_q + 1'b1) == wr_ptr_q);

endmodule

`default_nettype wire

/* File: vmb_sdp_buffer.sv */
// Purpose: Frame-synchronous extension metadata packet source with two ping-pong buffers.
// Assumes: Transcoder timing inputs come from logic on sys_clk_i; no synchronisers needed.
// Notes:   One packet is nine dwords on the slot port: a header then eight payload dwords, or nine buffer dwords in block mode.
`timescale 1ns/100ps
`default_nettype none
`include "vmb_params.svh"

module vmb_sdp_buffer
    import vmb_pkg::*;
#(
    parameter int unsigned BUF_WORDS = `VMB_BUF_WORDS
) (
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_i,
    // Register port
    input  wire logic [`VMB_ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]            reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [31:0]            reg_rdata_o,
    // Transcoder timing
    input  wire logic                   trans_enable_i,
    input  wire logic                   variable_refresh_i,
    input  wire logic                   vblank_i,
    input  wire logic                   delayed_vblank_i,
    input  wire logic                   line_start_i,
    // Vblank packet slot
    output logic                        pkt_valid_o,
    output logic      [31:0]            pkt_data_o,
    output logic                        pkt_sop_o,
    output logic                        pkt_eop_o,
    input  wire logic                   pkt_ready_i
);
    localparam int unsigned AW = $clog2(BUF_WORDS) + 1;

    generate
        if (BUF_WORDS < `VMB_PKT_DWORDS + 1) begin : g_bad
            $error("vmb_sdp_buffer: BUF_WORDS too small for one packet");
        end
    endgenerate

    // ****************************************
    // Register state
    // ****************************************
    logic [1:0]                   auto_q;
    logic [1:0]                   ready_q;
    logic [1:0]                   empty_q;
    logic [1:0]                   clr_stat_q;
    logic [`VMB_CONF_COUNT_W-1:0] count_q;
    logic                         block_q;
    logic                         replay_cfg_q;
    logic                         replay_act_q;
    logic                         done_q;
    logic [31:0]                  header_q;
    logic [31:0]                  rdata_q;

    // ****************************************
    // Engine state
    // ****************************************
    vmb_state_t                   state_q;
    logic                         cur_q;
    logic [`VMB_DW_CNT_W-1:0]     dw_q;
    logic [`VMB_CONF_COUNT_W-1:0] pkt_cnt_q;
    logic                         sent_q;
    logic                         vb_q;
    logic [`VMB_LINE_W-1:0]       line_q;
    logic                         valid_q;
    logic [31:0]                  data_q;
    logic                         sop_q;
    logic                         eop_q;

    // ****************************************
    // Per-buffer wiring
    // ****************************************
    logic [1:0]  ctl_wr;
    logic [1:0]  data_wr;
    logic [1:0]  sw_clear;
    logic [1:0]  hw_drain;
    logic [1:0]  buf_done;
    logic [1:0]  tx_begin;
    logic [1:0]  rd_en;
    logic        rewind;
    logic [1:0]  has;
    logic [1:0]  last;
    logic [1:0]  avail;
    logic [31:0] rdat [2];

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_buf
            vmb_buf_if #(.WIDTH(32), .AW(AW)) bif ();

            assign ctl_wr[b]   = reg_wr_i && (reg_addr_i == (b == 0 ? `VMB_ADDR_CTL0 : `VMB_ADDR_CTL1));
            assign data_wr[b]  = reg_wr_i && (reg_addr_i == (b == 0 ? `VMB_ADDR_DATA0 : `VMB_ADDR_DATA1));
            assign sw_clear[b] = ctl_wr[b] && ready_q[b] && !reg_wdata_i[`VMB_CTL_READY_BIT];
            assign bif.wr_en    = data_wr[b];
            assign bif.wr_data  = reg_wdata_i;
            assign bif.auto_inc = auto_q[b];
            assign bif.rd_en    = rd_en[b];
            assign bif.rewind   = rewind;
            assign bif.clear    = sw_clear[b] || hw_drain[b];
            assign has[b]       = bif.has_data;
            assign last[b]      = bif.rd_last;
            assign rdat[b]      = bif.rd_data;
            assign avail[b]     = ready_q[b] && bif.has_data;

            vmb_meta_fifo #(.DEPTH(BUF_WORDS), .WIDTH(32), .AW(AW)) u_fifo (
                .sys_clk_i (sys_clk_i),
                .reset_i   (reset_i),
                .port_if   (bif)
            );

            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    auto_q[b]  <= 1'b0;
                    ready_q[b] <= 1'b0;
                end else if (ctl_wr[b]) begin
                    auto_q[b]  <= reg_wdata_i[`VMB_CTL_AUTO_BIT];
                    ready_q[b] <= reg_wdata_i[`VMB_CTL_READY_BIT];
                end else if (hw_drain[b]) begin
                    ready_q[b] <= 1'b0;
                end
            end

            // A data write or a transmission start clears empty; finishing sets it and wins.
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    empty_q[b] <= 1'b1;
                end else if (buf_done[b] || bif.clear) begin
                    empty_q[b] <= 1'b1;
                end else if (tx_begin[b] || data_wr[b]) begin
                    empty_q[b] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (reset_i || bif.clear) begin
                    clr_stat_q[b] <= 1'b1;
                end else if (data_wr[b] || (ctl_wr[b] && reg_wdata_i[`VMB_CTL_READY_BIT])) begin
                    clr_stat_q[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // Configuration and header
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            count_q      <= '0;
            block_q      <= 1'b0;
            replay_cfg_q <= 1'b0;
            header_q     <= `VMB_HDR_RESET;
        end else if (reg_wr_i && reg_addr_i == `VMB_ADDR_CONF) begin
            count_q      <= reg_wdata_i[`VMB_CONF_COUNT_W-1:0];
            block_q      <= reg_wdata_i[`VMB_CONF_BLOCK_BIT];
            replay_cfg_q <= reg_wdata_i[`VMB_CONF_REPLAY_BIT];
        end else if (reg_wr_i && reg_addr_i == `VMB_ADDR_HDR) begin
            header_q     <= reg_wdata_i;
        end
    end

    // The live replay mode only follows the setting when software invalidates a buffer.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            replay_act_q <= 1'b0;
        end else if (sw_clear != 2'b00) begin
            replay_act_q <= replay_cfg_q;
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr_i)
            `VMB_ADDR_CTL0, `VMB_ADDR_CTL1: begin
                rd_mux[`VMB_CTL_AUTO_BIT]  = auto_q[reg_addr_i[2]];
                rd_mux[`VMB_CTL_READY_BIT] = ready_q[reg_addr_i[2]];
                rd_mux[`VMB_CTL_EMPTY_BIT] = empty_q[reg_addr_i[2]];
                rd_mux[`VMB_CTL_CLEAR_BIT] = clr_stat_q[reg_addr_i[2]];
            end
            `VMB_ADDR_CONF: begin
                rd_mux[`VMB_CONF_COUNT_W-1:0]  = count_q;
                rd_mux[`VMB_CONF_BLOCK_BIT]    = block_q;
                rd_mux[`VMB_CONF_REPLAY_BIT]   = replay_cfg_q;
                rd_mux[`VMB_CONF_DONE_BIT]     = done_q;
            end
            `VMB_ADDR_HDR: begin
                rd_mux = header_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Vblank line tracking
    // ****************************************
    logic                   vb;
    logic [`VMB_LINE_W-1:0] start_line;

    assign vb         = variable_refresh_i ? delayed_vblank_i : vblank_i;
    assign start_line = variable_refresh_i ? `VMB_VRR_START_LINE : `VMB_START_LINE;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            vb_q   <= 1'b0;
            line_q <= '0;
        end else begin
            vb_q <= vb;
            if (!vb || !vb_q) begin
                line_q <= '0;
            end else if (vb && line_start_i && line_q != '1) begin
                line_q <= `VMB_LINE_W'(line_q + 1'b1);
            end
        end
    end

    // ****************************************
    // Packet engine
    // ****************************************
    logic                         go;
    logic                         step;
    logic                         reg_hdr;
    logic                         pkt_end;
    logic                         cnt_hit;
    logic                         other_av;
    logic                         switch_buf;
    logic                         chain_end;
    logic                         starved;
    logic [`VMB_CONF_COUNT_W-1:0] pkt_next;

    // The line count is zero outside vblank, so a stale count cannot start a chain early.
    assign go = (state_q == ST_IDLE) && vb && trans_enable_i && (line_q >= start_line)
                && (avail != 2'b00) && !sent_q;
    assign step     = (state_q == ST_SEND) && (!valid_q || pkt_ready_i);
    assign reg_hdr  = !block_q && (dw_q == '0);
    assign starved  = step && !reg_hdr && !has[cur_q];
    assign pkt_end  = step && !starved && (dw_q == `VMB_DW_CNT_W'(`VMB_PKT_DWORDS));
    assign pkt_next = `VMB_CONF_COUNT_W'(pkt_cnt_q + 1'b1);
    assign cnt_hit  = !block_q && (pkt_next == count_q);
    assign other_av = avail[!cur_q] && !cur_q;
    assign switch_buf = pkt_end && last[cur_q] && other_av && !cnt_hit;
    assign chain_end  = (pkt_end && !switch_buf && (last[cur_q] || cnt_hit)) || starved;

    always_comb begin
        rd_en    = 2'b00;
        tx_begin = 2'b00;
        buf_done = 2'b00;
        hw_drain = 2'b00;
        rd_en[cur_q] = step && !reg_hdr && has[cur_q];
        if (go) begin
            tx_begin[avail[0] ? 1'b0 : 1'b1] = 1'b1;
        end
        if (switch_buf) begin
            tx_begin[!cur_q] = 1'b1;
        end
        if ((pkt_end && last[cur_q]) || starved) begin
            buf_done[cur_q] = 1'b1;
            hw_drain[cur_q] = !replay_act_q;
        end
    end

    // Replay rewinds both buffers so the same chain goes out in the next frame.
    assign rewind = chain_end && replay_act_q;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q   <= ST_IDLE;
            cur_q     <= 1'b0;
            dw_q      <= '0;
            pkt_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q   <= ST_SEND;
                        cur_q     <= !avail[0];
                        dw_q      <= block_q ? `VMB_DW_CNT_W'(0) : `VMB_DW_CNT_W'(0);
                        pkt_cnt_q <= '0;
                    end
                end
                ST_SEND: begin
                    if (chain_end) begin
                        state_q <= ST_IDLE;
                    end else if (pkt_end) begin
                        dw_q      <= '0;
                        pkt_cnt_q <= pkt_next;
                        if (switch_buf) begin
                            cur_q <= 1'b1;
                        end
                    end else if (step) begin
                        dw_q <= `VMB_DW_CNT_W'(dw_q + 1'b1);
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // One chain per frame in replay; the flag drops when vblank ends.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !vb) begin
            sent_q <= 1'b0;
        end else if (chain_end && replay_act_q) begin
            sent_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            done_q <= 1'b0;
        end else if (chain_end && !starved) begin
            done_q <= 1'b1;
        end else if (go) begin
            done_q <= 1'b0;
        end
    end

    // ****************************************
    // Slot output stage
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            valid_q <= 1'b0;
            data_q  <= 32'h0000_0000;
            sop_q   <= 1'b0;
            eop_q   <= 1'b0;
        end else if (step && !starved) begin
            valid_q <= 1'b1;
            data_q  <= reg_hdr ? header_q : rdat[cur_q];
            sop_q   <= (dw_q == '0);
            eop_q   <= (dw_q == `VMB_DW_CNT_W'(`VMB_PKT_DWORDS));
        end else if (pkt_ready_i) begin
            valid_q <= 1'b0;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign pkt_valid_o = valid_q;
    assign pkt_data_o  = data_q;
    assign pkt_sop_o   = sop_q;
    assign pkt_eop_o   = eop_q;

endmodule

`default_nettype wire

/* File: vmb_sdp_checker.sv */
// Purpose: Port assertions for the metadata packet source.
// Assumes: Bound to vmb_sdp_buffer; one clock domain.
// Notes:   Helper counters track dword position and lines into vblank.
`timescale 1ns/100ps
`default_nettype none
module vmb_sdp_checker (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    // Register port
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Transcoder timing
    input wire logic        trans_enable_i,
    input wire logic        variable_refresh_i,
    input wire logic        vblank_i,
    input wire logic        delayed_vblank_i,
    input wire logic        line_start_i,
    // Slot
    input wire logic        pkt_valid_o,
    input wire logic [31:0] pkt_data_o,
    input wire logic        pkt_sop_o,
    input wire logic        pkt_eop_o,
    input wire logic        pkt_ready_i
);
    logic [3:0] beat_q;
    logic [4:0] line_q;
    wire        take = pkt_valid_o && pkt_ready_i;
    wire        vb   = variable_refresh_i ? delayed_vblank_i : vblank_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || (take && pkt_eop_o)) beat_q <= '0;
        else if (take) beat_q <= beat_q + 4'h1;
    end
    // The line count saturates so a long vblank cannot wrap it below the start line.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !vb) line_q <= '0;
        else if (line_start_i && line_q != 5'h1f) line_q <= line_q + 5'h01;
    end
    sequence ready_drop_s;
        reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[16] ##2
        reg_wr_i && reg_addr_i == 8'h00 && !reg_wdata_i[16];
    endsequence
    hold_dword_a: assert property (pkt_valid_o && !pkt_ready_i |=>
        pkt_valid_o && $stable(pkt_data_o)) else $error("slot dword not held");
    sop_place_a: assert property (pkt_valid_o |-> pkt_sop_o == (beat_q == 4'h0))
        else $error("start flag off the header dword");
    eop_place_a: assert property (pkt_valid_o |-> pkt_eop_o == (beat_q == 4'h8))
        else $error("end flag off the ninth dword");
    off_quiet_a: assert property (!trans_enable_i && !pkt_valid_o |=> !pkt_valid_o)
        else $error("send while transcoder off");
    start_line_a: assert property ($rose(pkt_valid_o) |->
        line_q >= (variable_refresh_i ? 5'd3 : 5'd8)) else $error("send before start line");
    data_wo_a: assert property (reg_rd_i && reg_addr_i == 8'h10 |=> reg_rdata_o == 32'h0)
        else $error("data port read not zero");
    clear_status_a: assert property (ready_drop_s ##2 reg_rd_i && reg_addr_i == 8'h00
        |=> reg_rdata_o[25:24] == 2'b11) else $error("clear or empty not shown");
    reset_idle_a: assert property ($fell(reset_i) |-> !pkt_valid_o && reg_rdata_o == 32'h0)
        else $error("outputs busy after reset");
endmodule
`default_nettype wire

/* File: vmb_slot_model.sv */
// Purpose: Vblank packet slot that takes dwords, promptly or with stalls.
// Assumes: Same clock as the packet source.
// Notes:   Keeps a packet count and a wrapping sum of taken dwords.
`timescale 1ns/100ps
`default_nettype none
module vmb_slot_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // Slot
    input  wire logic        pkt_valid_i,
    input  wire logic [31:0] pkt_data_i,
    input  wire logic        pkt_eop_i,
    input  wire logic        slow_i,
    output logic             pkt_ready_o,
    // Tallies
    output logic [7:0]       pkts_o,
    output logic [31:0]      sum_o
);
    // Stalling every other cycle shows whether the source holds a dword until taken.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pkt_ready_o <= 1'b0;
            pkts_o <= '0;
            sum_o <= '0;
        end else begin
            pkt_ready_o <= slow_i ? !pkt_ready_o : 1'b1;
            if (pkt_valid_i && pkt_ready_o) begin
                sum_o <= sum_o + pkt_data_i;
                if (pkt_eop_i) pkts_o <= pkts_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the metadata packet source.
// Assumes: Read data stands in the cycle after the strobe.
// Notes:   The bench makes frames; the slot model stalls on request.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        sys_clk_i, reset_i, reg_wr_i, reg_rd_i, slow;
    logic [7:0]  reg_addr_i, pkts;
    logic [31:0] reg_wdata_i, reg_rdata_o, pkt_data_o, sum;
    logic        trans_enable_i, variable_refresh_i, vblank_i, delayed_vblank_i, line_start_i;
    logic        pkt_valid_o, pkt_sop_o, pkt_eop_o, pkt_ready_i;
    int          n_mismatch, samples_checked;
    vmb_sdp_buffer #(.BUF_WORDS(256)) DUT (.sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .trans_enable_i, .variable_refresh_i, .vblank_i,
        .delayed_vblank_i, .line_start_i, .pkt_valid_o, .pkt_data_o, .pkt_sop_o, .pkt_eop_o,
        .pkt_ready_i);
    vmb_slot_model u_slot (.sys_clk_i, .reset_i, .pkt_valid_i(pkt_valid_o),
        .pkt_data_i(pkt_data_o), .pkt_eop_i(pkt_eop_o), .slow_i(slow),
        .pkt_ready_o(pkt_ready_i), .pkts_o(pkts), .sum_o(sum));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string nm);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o & m, e, nm);
        @(posedge sys_clk_i);
    endtask
    task automatic fill(input logic [7:0] a, input int n, input logic [31:0] b);
        for (int i = 0; i < n; i++) wr(a, b + i);
    endtask
    // One frame: a vblank of twenty lines, then the tallies of what the slot took.
    task automatic frame(input logic variable_refresh, input logic [31:0] n_exp, s_exp);
        logic [7:0]  p0;
        logic [31:0] s0;
        p0 = pkts;
        s0 = sum;
        variable_refresh_i <= variable_refresh;
        vblank_i <= !variable_refresh;
        delayed_vblank_i <= variable_refresh;
        for (int i = 0; i < 400; i++) begin
            line_start_i <= (i % 20 == 5);
            @(posedge sys_clk_i);
        end
        vblank_i <= 1'b0;
        delayed_vblank_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk(32'(pkts - p0), n_exp, "packets");
        chk(sum - s0, s_exp, "dword sum");
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {n_mismatch, samples_checked} = '0;
        {reset_i, trans_enable_i} = 2'b11;
        {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, slow} = '0;
        {variable_refresh_i, vblank_i, delayed_vblank_i, line_start_i} = '0;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(8'h00, 32'hffff_ffff, 32'h0300_0000, "ping control");
        rd(8'h04, 32'hffff_ffff, 32'h0300_0000, "pong control");
        rd(8'h08, 32'hffff_ffff, 32'h0000_0000, "config");
        rd(8'h20, 32'hffff_ffff, 32'h0000_0000, "unmapped");
        slow <= 1'b1;
        wr(8'h08, 32'h0000_0002);
        wr(8'h0c, 32'h00ab_0001);
        wr(8'h00, 32'h0000_4000);
        fill(8'h10, 16, 32'h1000_0000);
        wr(8'h00, 32'h0001_4000);
        rd(8'h00, 32'h0101_0000, 32'h0001_0000, "ping ready");
        rd(8'h10, 32'hffff_ffff, 32'h0000_0000, "data port");
        frame(1'b0, 2, 2 * 32'h00ab_0001 + 16 * 32'h1000_0000 + 120);
        rd(8'h00, 32'h0101_0000, 32'h0100_0000, "ping empty");
        rd(8'h08, 32'h8000_0000, 32'h8000_0000, "chain done");
        slow <= 1'b0;
        trans_enable_i <= 1'b0;
        wr(8'h08, 32'h0040_0005);
        wr(8'h00, 32'h0000_4000);
        wr(8'h04, 32'h0000_4000);
        fill(8'h10, 9, 32'h2000_0000);
        fill(8'h14, 9, 32'h3000_0000);
        wr(8'h00, 32'h0001_4000);
        wr(8'h04, 32'h0001_4000);
        frame(1'b1, 0, 0);
        trans_enable_i <= 1'b1;
        frame(1'b1, 2, 9 * 32'h2000_0000 + 9 * 32'h3000_0000 + 72);
        rd(8'h08, 32'h8000_0000, 32'h8000_0000, "block done");
        rd(8'h04, 32'h0101_0000, 32'h0100_0000, "pong empty");
        wr(8'h08, 32'h0080_0001);
        wr(8'h00, 32'h0001_4000);
        wr(8'h00, 32'h0000_4000);
        rd(8'h00, 32'h0300_0000, 32'h0300_0000, "clear status");
        fill(8'h10, 8, 32'h4000_0000);
        wr(8'h00, 32'h0001_4000);
        repeat (2) frame(1'b0, 1, 32'h00ab_0001 + 8 * 32'h4000_0000 + 28);
        stop_test();
    end
endmodule
bind vmb_sdp_buffer vmb_sdp_checker u_chk (.sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .trans_enable_i, .variable_refresh_i, .vblank_i,
    .delayed_vblank_i, .line_start_i, .pkt_valid_o, .pkt_data_o, .pkt_sop_o, .pkt_eop_o,
    .pkt_ready_i);
`default_nettype wire
